// *** fer_ecc_report.sv ***
// Flash array ECC generation, checking and error reporting with a link-clock command port
`timescale 1ns/1ns
// Summary of operation
// - Program computes a hidden code per 16-byte unit; reads of programmed units with ECC on check it.
// - Reads of programmed units with ECC on correct any single-bit error before data goes back.
// - Single-bit mode: repeat program without erase disables unit ECC, sets off flag.
// - A disabled unit regains ECC only when its sector is erased.
// - Default double-bit mode uses a 9-bit code, corrects one, detects two.
// - Double-bit mode rejects any repeat program to a unit and flags program error.
// - Unit status: bit3 double detected, bit1 single corrected, bit0 ECC off, rest 0.
// - With volatile mode bit 0 the double-bit unit flag always reads 0.
// - Double-bit mode repeat program never sets the off flag, only program error.
// - 8-bit status register accumulates error events from array reads.
// - Status register clears on any reset or the clear command.
// - 32-bit trap holds the address of the first error seen by array reads.
// - Trap takes first error of type chosen by nonvolatile mode bit.
// - Several failing units in one read keep only the first address.
// - Trap holds the accessed address; bad bits lie in its aligned unit.
// - A unit with ECC disabled never reports an error nor loads the trap.
// - Trap is valid only while status bit 3 or bit 4 is set.
// - Trap clears on the clear command and on every reset.
// - Read-any-register returns current status register and trap contents.
// - Optional interrupt output signals single or double errors during reads.
module fer_ecc_report
   import fer_pkg::*;
#(
   parameter int NUM_UNITS        = 16,
   parameter int UNITS_PER_SECTOR = 4
) (
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire logic       cs_reset,
   input  wire logic       sw_reset,
   input  wire logic [7:0] volatile_ecc_mode_config,
   input  wire logic [7:0] nonvolatile_ecc_mode_config,
   input  wire logic       int_enable,
   output logic            ecc_int_b,
   input  wire logic       lnk_clk,
   input  wire logic       lnk_rst_b,
   input  wire logic       cmd_valid,
   input  wire fer_cmd_s   cmd,
   output logic            cmd_ready,
   output logic            rsp_valid,
   output fer_rsp_s        rsp
);
   localparam int IDX_W = (NUM_UNITS > 1) ? $clog2(NUM_UNITS) : 1;

   typedef enum {LNK_IDLE, LNK_WAIT} fer_lnk_e;

   // Link domain state
   fer_lnk_e             lnk_st_q;
   fer_lnk_e             lnk_st_d;
   fer_cmd_s             lnk_cmd_q;
   fer_cmd_s             lnk_cmd_d;
   logic                 lnk_req_q;
   logic                 lnk_req_d;
   logic                 ready_q;
   logic                 ready_d;
   logic                 rvalid_q;
   logic                 rvalid_d;
   fer_rsp_s             lrsp_q;
   fer_rsp_s             lrsp_d;
   logic                 ack_s1_q;
   logic                 ack_s2_q;
   logic                 ack_s3_q;

   // Core domain state
   logic                 rq_s1_q;
   logic                 rq_s2_q;
   logic                 rq_s3_q;
   logic                 seen_q;
   logic                 seen_d;
   logic                 ack_q;
   logic                 ack_d;
   fer_rsp_s             hold_q;
   fer_rsp_s             hold_d;
   logic [STAT_W-1:0]    stat_q;
   logic [STAT_W-1:0]    stat_d;
   logic [ADDR_W-1:0]    trap_q;
   logic [ADDR_W-1:0]    trap_d;
   logic                 trap_full_q;
   logic                 trap_full_d;
   logic                 int_b_q;
   logic                 int_b_d;

   // Array storage, with the code in space the host cannot address
   logic [UNIT_BITS-1:0] arr_data_q [NUM_UNITS];
   logic [UNIT_BITS-1:0] arr_data_d [NUM_UNITS];
   logic [CODE_BITS-1:0] arr_code_q [NUM_UNITS];
   logic [CODE_BITS-1:0] arr_code_d [NUM_UNITS];
   logic                 arr_prog_q [NUM_UNITS];
   logic                 arr_prog_d [NUM_UNITS];
   logic                 arr_off_q  [NUM_UNITS];
   logic                 arr_off_d  [NUM_UNITS];
   logic                 arr_we;
   logic                 arr_erase;
   logic [IDX_W-1:0]     arr_idx;
   logic [UNIT_BITS-1:0] arr_wdata;
   logic [CODE_BITS-1:0] arr_wcode;
   logic                 arr_wprog;
   logic                 arr_woff;

   function automatic logic [CHECK_BITS-1:0] ham(input logic [UNIT_BITS-1:0] d);
      logic [CHECK_BITS-1:0] c;
      int                    k;
      c = '0;
      k = 0;
      for (int p = 1; p <= CODE_POSITIONS; p++) begin
         if ((p & (p - 1)) != 0) begin
            if (d[k]) begin
               c = c ^ CHECK_BITS'(p);
            end
            k++;
         end
      end
      return c;
   endfunction : ham

   function automatic fer_dec_s decode(input logic [UNIT_BITS-1:0] d,
                                       input logic [CODE_BITS-1:0] code,
                                       input logic                 dbl_mode);
      fer_dec_s              r;
      logic [CHECK_BITS-1:0] syn;
      logic                  perr;
      int                    k;
      r.data = d;
      r.sgl  = 1'b0;
      r.dbl  = 1'b0;
      k      = 0;
      syn    = ham(d) ^ code[CHECK_BITS-1:0];
      perr   = (^d) ^ (^code);
      if (dbl_mode) begin
         r.sgl = perr;
         r.dbl = !perr && (syn != '0);
      end else begin
         r.sgl = (syn != '0);
      end
      if (r.sgl) begin
         for (int p = 1; p <= CODE_POSITIONS; p++) begin
            if ((p & (p - 1)) != 0) begin
               if (CHECK_BITS'(p) == syn) begin
                  r.data[k] = ~d[k];
               end
               k++;
            end
         end
      end
      return r;
   endfunction : decode

   // Link domain
   // The link clock must keep running until the answer returns; a stalled clock holds the request.
   always_comb begin
      lnk_st_d  = lnk_st_q;
      lnk_cmd_d = lnk_cmd_q;
      lnk_req_d = lnk_req_q;
      ready_d   = (lnk_st_q == LNK_IDLE);
      rvalid_d  = 1'b0;
      lrsp_d    = lrsp_q;
      unique case (lnk_st_q)
         LNK_IDLE: begin
            if (cmd_valid && ready_q) begin
               lnk_cmd_d = cmd;
               lnk_req_d = ~lnk_req_q;
               ready_d   = 1'b0;
               lnk_st_d  = LNK_WAIT;
            end
         end
         LNK_WAIT: begin
            if ((ack_s2_q == ack_s3_q) && (ack_s3_q == lnk_req_q)) begin
               lrsp_d   = hold_q;
               rvalid_d = 1'b1;
               ready_d  = 1'b1;
               lnk_st_d = LNK_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge lnk_clk) begin
      if (!lnk_rst_b) begin
         lnk_st_q  <= LNK_IDLE;
         lnk_cmd_q <= '0;
         lnk_req_q <= 1'b0;
         ready_q   <= 1'b0;
         rvalid_q  <= 1'b0;
         lrsp_q    <= '0;
         ack_s1_q  <= 1'b0;
         ack_s2_q  <= 1'b0;
         ack_s3_q  <= 1'b0;
      end else begin
         lnk_st_q  <= lnk_st_d;
         lnk_cmd_q <= lnk_cmd_d;
         lnk_req_q <= lnk_req_d;
         ready_q   <= ready_d;
         rvalid_q  <= rvalid_d;
         lrsp_q    <= lrsp_d;
         ack_s1_q  <= ack_q;
         ack_s2_q  <= ack_s1_q;
         ack_s3_q  <= ack_s2_q;
      end
   end

   // Core domain
   logic                 rq_new;
   logic                 dbl_mode;
   logic                 trap_any;
   logic                 clr;
   logic                 hit;
   logic                 sgl_ev;
   logic                 dbl_ev;
   logic [IDX_W-1:0]     idx;
   logic [UNIT_BITS-1:0] pdata;
   logic [STAT_W-1:0]    ustat;
   fer_dec_s             dec;

   // The held command is read across domains only while the request toggle is settled;
   // the link side cannot take a new one until the answer toggle comes back
   always_comb begin
      rq_new    = (rq_s2_q == rq_s3_q) && (rq_s3_q != seen_q);
      dbl_mode  = volatile_ecc_mode_config[ECC_MODE_BIT];
      trap_any  = nonvolatile_ecc_mode_config[ECC_MODE_BIT];
      idx       = lnk_cmd_q.addr[UNIT_SHIFT +: IDX_W];
      dec       = decode(arr_data_q[idx], arr_code_q[idx], dbl_mode);
      hit       = arr_prog_q[idx] && !arr_off_q[idx];
      pdata     = arr_data_q[idx];
      for (int b = 0; b < UNIT_BYTES; b++) begin
         if (lnk_cmd_q.mask[b]) begin
            pdata[b*8 +: 8] = arr_data_q[idx][b*8 +: 8] & lnk_cmd_q.data[b*8 +: 8];
         end
      end
      ustat     = '0;
      ustat[UST_OFF_BIT] = arr_off_q[idx];
      ustat[UST_SGL_BIT] = hit && dec.sgl;
      ustat[UST_DBL_BIT] = hit && dec.dbl && dbl_mode;
      sgl_ev    = 1'b0;
      dbl_ev    = 1'b0;
      clr       = cs_reset || sw_reset;
      seen_d    = seen_q;
      ack_d     = ack_q;
      hold_d    = hold_q;
      arr_we    = 1'b0;
      arr_erase = 1'b0;
      arr_idx   = idx;
      arr_wdata = arr_data_q[idx];
      arr_wcode = arr_code_q[idx];
      arr_wprog = arr_prog_q[idx];
      arr_woff  = arr_off_q[idx];
      if (rq_new) begin
         seen_d = rq_s3_q;
         ack_d  = rq_s3_q;
         hold_d = '0;
         unique case (lnk_cmd_q.op)
            CMD_READ: begin
               hold_d.data = hit ? dec.data : arr_data_q[idx];
               sgl_ev      = hit && dec.sgl;
               dbl_ev      = hit && dec.dbl;
            end
            CMD_PROGRAM: begin
               arr_wdata = pdata;
               if (!arr_prog_q[idx]) begin
                  arr_we    = 1'b1;
                  arr_wprog = 1'b1;
                  arr_wcode = {(^pdata) ^ (^ham(pdata)), ham(pdata)};
               end else if (dbl_mode) begin
                  hold_d.prog_err = 1'b1;
               end else begin
                  arr_we   = 1'b1;
                  arr_woff = 1'b1;
               end
            end
            CMD_ERASE: begin
               arr_erase = 1'b1;
            end
            CMD_UNIT_STATUS: begin
               hold_d.status = ustat;
            end
            CMD_CLEAR_ECC: begin
               clr = 1'b1;
            end
            CMD_READ_REG: begin
               if (lnk_cmd_q.addr == REG_STATUS) begin
                  hold_d.data[STAT_W-1:0] = stat_q;
               end else if (lnk_cmd_q.addr == REG_TRAP) begin
                  hold_d.data[ADDR_W-1:0] = trap_q;
               end
            end
            CMD_INJECT: begin
               // Disturb path for bring-up: flips stored bits without touching the code
               arr_we    = 1'b1;
               arr_wdata = arr_data_q[idx] ^ lnk_cmd_q.data;
            end
            CMD_NOP: begin
            end
         endcase
      end
      // An error in the same cycle as a clear survives the clear
      stat_d = clr ? ESR_RESET : stat_q;
      stat_d[ESR_SGL_BIT] = stat_d[ESR_SGL_BIT] | sgl_ev;
      stat_d[ESR_DBL_BIT] = stat_d[ESR_DBL_BIT] | dbl_ev;
      trap_d      = clr ? TRAP_RESET : trap_q;
      trap_full_d = clr ? 1'b0 : trap_full_q;
      if ((dbl_ev || (trap_any && sgl_ev)) && !trap_full_d) begin
         trap_d      = lnk_cmd_q.addr;
         trap_full_d = 1'b1;
      end
      int_b_d = !(int_enable && (stat_d[ESR_SGL_BIT] || stat_d[ESR_DBL_BIT]));
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         rq_s1_q     <= 1'b0;
         rq_s2_q     <= 1'b0;
         rq_s3_q     <= 1'b0;
         seen_q      <= 1'b0;
         ack_q       <= 1'b0;
         hold_q      <= '0;
         stat_q      <= ESR_RESET;
         trap_q      <= TRAP_RESET;
         trap_full_q <= 1'b0;
         int_b_q     <= 1'b1;
      end else begin
         rq_s1_q     <= lnk_req_q;
         rq_s2_q     <= rq_s1_q;
         rq_s3_q     <= rq_s2_q;
         seen_q      <= seen_d;
         ack_q       <= ack_d;
         hold_q      <= hold_d;
         stat_q      <= stat_d;
         trap_q      <= trap_d;
         trap_full_q <= trap_full_d;
         int_b_q     <= int_b_d;
      end
   end

   // Next array contents; an erase wipes every unit of the addressed sector
   always_comb begin
      for (int u = 0; u < NUM_UNITS; u++) begin
         arr_data_d[u] = arr_data_q[u];
         arr_code_d[u] = arr_code_q[u];
         arr_prog_d[u] = arr_prog_q[u];
         arr_off_d[u]  = arr_off_q[u];
         if (arr_erase && ((u / UNITS_PER_SECTOR) == (int'(arr_idx) / UNITS_PER_SECTOR))) begin
            arr_data_d[u] = '1;
            arr_code_d[u] = '0;
            arr_prog_d[u] = 1'b0;
            arr_off_d[u]  = 1'b0;
         end else if (arr_we && (u == int'(arr_idx))) begin
            arr_data_d[u] = arr_wdata;
            arr_code_d[u] = arr_wcode;
            arr_prog_d[u] = arr_wprog;
            arr_off_d[u]  = arr_woff;
         end
      end
   end

   // Reset leaves every unit erased so simulations start from a known array
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         for (int u = 0; u < NUM_UNITS; u++) begin
            arr_data_q[u] <= '1;
            arr_code_q[u] <= '0;
            arr_prog_q[u] <= 1'b0;
            arr_off_q[u]  <= 1'b0;
         end
      end else begin
         for (int u = 0; u < NUM_UNITS; u++) begin
            arr_data_q[u] <= arr_data_d[u];
            arr_code_q[u] <= arr_code_d[u];
            arr_prog_q[u] <= arr_prog_d[u];
            arr_off_q[u]  <= arr_off_d[u];
         end
      end
   end

   assign ecc_int_b = int_b_q;
   assign cmd_ready = ready_q;
   assign rsp_valid = rvalid_q;
   assign rsp       = lrsp_q;
endmodule : fer_ecc_report

// *** fer_pkg.sv ***
// Shared constants, commands and carriers of the flash array ECC reporting block
package fer_pkg;
   localparam int          UNIT_BYTES     = 16;
   localparam int          UNIT_BITS      = UNIT_BYTES * 8;
   localparam int          CHECK_BITS     = 8;
   localparam int          CODE_BITS      = CHECK_BITS + 1;
   localparam int          CODE_POSITIONS = UNIT_BITS + CHECK_BITS;
   localparam int          UNIT_SHIFT     = 4;
   localparam int          ADDR_W         = 32;
   localparam int          STAT_W         = 8;
   // Configuration bit that selects the ECC mode in the volatile byte, the trap error type in the nonvolatile byte
   localparam int          ECC_MODE_BIT   = 3;
   // Unit status fields
   localparam int          UST_DBL_BIT    = 3;
   localparam int          UST_SGL_BIT    = 1;
   localparam int          UST_OFF_BIT    = 0;
   // ECC status register fields
   localparam int          ESR_SGL_BIT    = 3;
   localparam int          ESR_DBL_BIT    = 4;
   localparam logic [7:0]  ESR_RESET      = 8'h00;
   localparam logic [31:0] TRAP_RESET     = 32'h0000_0000;
   // Register selectors for the read-any-register command
   localparam logic [31:0] REG_STATUS     = 32'h0000_0089;
   localparam logic [31:0] REG_TRAP       = 32'h0000_008A;

   typedef enum logic [2:0] {
      CMD_READ,
      CMD_PROGRAM,
      CMD_ERASE,
      CMD_UNIT_STATUS,
      CMD_CLEAR_ECC,
      CMD_READ_REG,
      CMD_INJECT,
      CMD_NOP
   } fer_cmd_e;

   typedef struct packed {
      fer_cmd_e                  op;
      logic [ADDR_W-1:0]         addr;
      logic [UNIT_BITS-1:0]      data;
      logic [UNIT_BYTES-1:0]     mask;
   } fer_cmd_s;

   typedef struct packed {
      logic [UNIT_BITS-1:0]      data;
      logic [STAT_W-1:0]         status;
      logic                      prog_err;
   } fer_rsp_s;

   typedef struct packed {
      logic [UNIT_BITS-1:0]      data;
      logic                      sgl;
      logic                      dbl;
   } fer_dec_s;
endpackage : fer_pkg

// *** fer_ecc_report_checker.sv ***
// Concurrent checks on the ports of the ECC reporting block
`timescale 1ns/1ns
module fer_ecc_report_checker
   import fer_pkg::*;
(
   input wire logic       mclk,
   input wire logic       rst_b,
   input wire logic       cs_reset,
   input wire logic       sw_reset,
   input wire logic [7:0] volatile_ecc_mode_config,
   input wire logic       int_enable,
   input wire logic       ecc_int_b,
   input wire logic       lnk_clk,
   input wire logic       lnk_rst_b,
   input wire logic       cmd_valid,
   input wire logic       cmd_ready,
   input wire logic       rsp_valid,
   input wire fer_rsp_s   rsp
);
   wire logic take = cmd_valid && cmd_ready;
   a_ready_drops: assert property (@(posedge lnk_clk) disable iff (!lnk_rst_b)
      take |=> !cmd_ready) else $error("ready stayed high after a take");
   a_answer_bound: assert property (@(posedge lnk_clk) disable iff (!lnk_rst_b)
      take |=> (!cmd_ready && !rsp_valid) [*4] ##[1:26] rsp_valid)
      else $error("no answer in time");
   a_rsp_pulse: assert property (@(posedge lnk_clk) disable iff (!lnk_rst_b)
      rsp_valid |=> !rsp_valid) else $error("answer valid longer than one cycle");
   a_rsp_holds: assert property (@(posedge lnk_clk) disable iff (!lnk_rst_b)
      !rsp_valid |-> $stable(rsp)) else $error("answer changed between answers");
   a_ready_back: assert property (@(posedge lnk_clk) disable iff (!lnk_rst_b)
      rsp_valid |-> cmd_ready) else $error("ready low in answer cycle");
   a_unit_reserved: assert property (@(posedge lnk_clk) disable iff (!lnk_rst_b)
      rsp_valid |-> rsp.status[7:4] == 4'h0 && !rsp.status[2])
      else $error("reserved status bits set");
   a_single_nodbl: assert property (@(posedge lnk_clk) disable iff (!lnk_rst_b)
      rsp_valid && !volatile_ecc_mode_config[3] |-> !rsp.status[3])
      else $error("double flag in single mode");
   a_dbl_nooff: assert property (@(posedge lnk_clk) disable iff (!lnk_rst_b)
      rsp_valid && volatile_ecc_mode_config[3] |-> !rsp.status[0])
      else $error("off flag in double mode");
   a_int_masked: assert property (@(posedge mclk) disable iff (!rst_b)
      !int_enable [*2] |=> ecc_int_b) else $error("interrupt low while disabled");
   a_clear_int: assert property (@(posedge mclk) disable iff (!rst_b)
      cs_reset || sw_reset |-> ##[1:3] ecc_int_b) else $error("interrupt kept after reset");
   c_prog_err: cover property (@(posedge lnk_clk) rsp_valid && rsp.prog_err);
   c_int_low: cover property (@(posedge mclk) !ecc_int_b);
   c_unit_off: cover property (@(posedge lnk_clk) rsp_valid && rsp.status[0]);
endmodule : fer_ecc_report_checker

bind fer_ecc_report fer_ecc_report_checker chk (
   .mclk(mclk), .rst_b(rst_b), .cs_reset(cs_reset), .sw_reset(sw_reset),
   .volatile_ecc_mode_config(volatile_ecc_mode_config), .int_enable(int_enable),
   .ecc_int_b(ecc_int_b), .lnk_clk(lnk_clk), .lnk_rst_b(lnk_rst_b), .cmd_valid(cmd_valid),
   .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp));

// *** fer_host_model.sv ***
// Host controller model on the link command port
`timescale 1ns/1ns
module fer_host_model
   import fer_pkg::*;
(
   input  wire logic     lnk_clk,
   input  wire logic     cmd_ready,
   input  wire logic     rsp_valid,
   input  wire fer_rsp_s rsp,
   output fer_cmd_s      cmd,
   output logic          cmd_valid
);
   initial begin
      cmd_valid = 1'b0;
      cmd       = '0;
   end
   // One command outstanding; raised only while ready so the next rising edge takes it
   task automatic xfer(input fer_cmd_e o, input logic [31:0] a, input logic [127:0] d,
                       input logic [15:0] m, output fer_rsp_s r);
      int n;
      @(negedge lnk_clk);
      for (n = 0; n < 60 && cmd_ready !== 1'b1; n++) @(negedge lnk_clk);
      cmd_valid = 1'b1;
      cmd       = '{o, a, d, m};
      @(negedge lnk_clk);
      cmd_valid = 1'b0;
      // Released lines must not keep showing the old request
      cmd       = ~cmd;
      for (n = 0; n < 40 && rsp_valid !== 1'b1; n++) @(negedge lnk_clk);
      r = rsp;
   endtask : xfer
endmodule : fer_host_model

// *** tb_flash_array_ecc_reporting.sv ***
// Self-checking bench for the ECC reporting block
`timescale 1ns/1ns
module tb_flash_array_ecc_reporting
   import fer_pkg::*;
;
   localparam logic [127:0] PA = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
   localparam logic [127:0] PB = {4{32'h1234_ABCD}};
   logic       mclk, rst_b, cs_reset, sw_reset, int_en, ecc_int_b, lnk_clk, lnk_rst_b;
   logic [7:0] vcfg, nvcfg;
   logic       cmd_valid, cmd_ready, rsp_valid;
   fer_cmd_s   cmd;
   fer_rsp_s   rsp, r;
   int         err_count, n_checks, cyc, i;

   fer_ecc_report #(.NUM_UNITS(16), .UNITS_PER_SECTOR(4)) dut (
      .mclk(mclk), .rst_b(rst_b), .cs_reset(cs_reset), .sw_reset(sw_reset),
      .volatile_ecc_mode_config(vcfg), .nonvolatile_ecc_mode_config(nvcfg),
      .int_enable(int_en), .ecc_int_b(ecc_int_b), .lnk_clk(lnk_clk), .lnk_rst_b(lnk_rst_b),
      .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
      .rsp(rsp));
   fer_host_model host (
      .lnk_clk(lnk_clk), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp),
      .cmd(cmd), .cmd_valid(cmd_valid));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // Link clock of 15 ns, phase unrelated to the core clock
   initial begin
      lnk_clk = 1'b0;
      #4;
      forever begin
         #7 lnk_clk = 1'b1;
         #8 lnk_clk = 1'b0;
      end
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : conclude

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         conclude();
      end
   end

   task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic op(input fer_cmd_e o, input logic [31:0] a, input logic [127:0] d,
                     input logic [15:0] m = 16'hFFFF);
      host.xfer(o, a, d, m, r);
      chk("answer valid", rsp_valid, 1'b1);
   endtask : op

   task automatic regs(input logic [7:0] st, input logic [31:0] tr);
      op(CMD_READ_REG, REG_STATUS, '0);
      chk("status reg", r.data[7:0], st);
      op(CMD_READ_REG, REG_TRAP, '0);
      chk("trap", r.data[31:0], tr);
   endtask : regs

   // A core reset also erases the modelled array
   task automatic do_reset(input logic [7:0] vmode);
      @(negedge mclk);
      rst_b     = 1'b0;
      lnk_rst_b = 1'b0;
      vcfg      = vmode;
      repeat (6) @(negedge mclk);
      rst_b     = 1'b1;
      lnk_rst_b = 1'b1;
   endtask : do_reset

   task automatic int_chk(input logic en, input logic exp);
      @(negedge mclk);
      int_en = en;
      repeat (3) @(negedge mclk);
      chk("interrupt", ecc_int_b, exp);
   endtask : int_chk

   initial begin
      rst_b = 1'b0;
      lnk_rst_b = 1'b0;
      cs_reset = 1'b0;
      sw_reset = 1'b0;
      int_en = 1'b1;
      vcfg = 8'h08;
      nvcfg = 8'h08;
      do_reset(8'h08);
      regs(8'h00, 32'h0);
      op(CMD_PROGRAM, 32'h10, PA);
      chk("first program", r.prog_err, 1'b0);
      op(CMD_PROGRAM, 32'h10, PB, 16'h0001);
      chk("repeat program", r.prog_err, 1'b1);
      op(CMD_UNIT_STATUS, 32'h10, '0);
      chk("unit status", r.status, 8'h00);
      op(CMD_INJECT, 32'h10, 128'h20);
      op(CMD_READ, 32'h14, '0);
      chk("corrected data", r.data, PA);
      op(CMD_UNIT_STATUS, 32'h10, '0);
      chk("unit single", r.status, 8'h02);
      regs(8'h08, 32'h14);
      int_chk(1'b1, 1'b0);
      op(CMD_PROGRAM, 32'h20, PB);
      op(CMD_INJECT, 32'h20, 128'h3);
      op(CMD_READ, 32'h28, '0);
      op(CMD_UNIT_STATUS, 32'h20, '0);
      chk("unit double", r.status, 8'h08);
      regs(8'h18, 32'h14);
      int_chk(1'b0, 1'b1);
      int_chk(1'b1, 1'b0);
      op(CMD_CLEAR_ECC, 32'h0, '0);
      regs(8'h00, 32'h0);
      chk("interrupt", ecc_int_b, 1'b1);
      @(negedge mclk);
      nvcfg = 8'h00;
      op(CMD_READ, 32'h14, '0);
      regs(8'h08, 32'h0);
      op(CMD_READ, 32'h2C, '0);
      regs(8'h18, 32'h2C);
      for (i = 0; i < 2; i++) begin
         @(negedge mclk);
         cs_reset = (i == 0);
         sw_reset = (i == 1);
         @(negedge mclk);
         cs_reset = 1'b0;
         sw_reset = 1'b0;
         regs(8'h00, 32'h0);
         op(CMD_READ, 32'h24, '0);
      end
      op(CMD_ERASE, 32'h3F, '0);
      op(CMD_READ, 32'h10, '0);
      chk("erased unit", r.data, '1);
      op(CMD_PROGRAM, 32'h10, PB);
      chk("program after erase", r.prog_err, 1'b0);
      for (i = 0; i < 4; i++) begin
         op(CMD_ERASE, i * 32'h40, '0);
      end
      do_reset(8'h00);
      op(CMD_PROGRAM, 32'h10, PA);
      op(CMD_INJECT, 32'h10, 128'h3);
      op(CMD_UNIT_STATUS, 32'h10, '0);
      chk("double flag", r.status[3], 1'b0);
      op(CMD_PROGRAM, 32'h30, PA, 16'h00FF);
      op(CMD_PROGRAM, 32'h30, PB, 16'hFF00);
      chk("second program", r.prog_err, 1'b0);
      op(CMD_UNIT_STATUS, 32'h30, '0);
      chk("unit off", r.status, 8'h01);
      op(CMD_INJECT, 32'h30, 128'h1);
      op(CMD_READ, 32'h30, '0);
      chk("raw data", r.data, {PB[127:64], PA[63:1], ~PA[0]});
      regs(8'h00, 32'h0);
      conclude();
   end
endmodule : tb_flash_array_ecc_reporting
